// ---- hdl/rail_seq_defs.svh ----
// command codes, reset values and timing counts of the rail-off sequencer
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH
`define CMD_VOUT_OV 8'h41
`define CMD_VOUT_UV 8'h45
`define CMD_VIN_OV 8'h56
`define CMD_TON_MAX 8'h63
`define CMD_OFF_DELAY 8'h64
`define CMD_FALL_TIME 8'h65
`define CMD_TOFF_WARN 8'h66
`define CMD_CHAN_CFG 8'hD0
`define CMD_RETRY 8'hDB
`define CMD_RESTART 8'hDC
`define RST_VIN_OV 8'h80
`define RST_OUT_RESP 8'hB8
`define RST_OFF_DELAY 16'h8000
`define RST_FALL_TIME 16'hD200
`define RST_TOFF_WARN 16'hF258
`define RST_RETRY 16'hFABC
`define RST_RESTART 16'hFBE8
`define RST_CHAN_CFG 8'h00
`define RESP_LATCH_OFF 8'h80
`define RESP_RETRY_ALL 3'h7
`define CFG_NO_RETRY_DECAY 0
`define CFG_DECAY_WAIT 1
`define CFG_CCM 2
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 10000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_MS (1000000 / `TICK_PERIOD_NS)
`define MS_TICKS(ms) ((ms) * `TICKS_PER_MS)
`define FALL_MIN_US 250
`define FALL_MIN_TICKS ((`FALL_MIN_US * 1000 + `TICK_PERIOD_NS - 1) / `TICK_PERIOD_NS)
`define FALL_MAX_MS 1300
`define DELAY_MAX_MS 83000
`define WARN_MIN_MS 120
`define WARN_MAX_MS 524000
`define RETRY_MIN_MS 120
`define RETRY_MAX_MS 83880
`define HOLD_MIN_MS 136
`define HOLD_MAX_MS 65520
`define SLOPE_MV_PER_MS 4000
`define SLOPE_MV_PER_TICK (`SLOPE_MV_PER_MS / `TICKS_PER_MS)
`define OFF_LEVEL_SHIFT 3
`endif

// ---- hdl/rail_seq_pkg.sv ----
// types shared by the rail-off sequencer
package rail_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_FALL,
        ST_TRI,
        ST_DECAY,
        ST_OFF,
        ST_RETRY,
        ST_LATCH
    } seq_state_t;
    typedef logic [26:0] ticks_t;
endpackage : rail_seq_pkg

// ---- hdl/linear_to_ticks.sv ----
// decodes a linear 5s/11s millisecond value into clamped 10us ticks
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
module linear_to_ticks #(
    parameter logic [26:0] MIN_TICKS = 27'h0000000,
    parameter logic [26:0] MAX_TICKS = 27'h7FFFFFF,
    parameter bit ZERO_PASS = 1'b0
) (
    input wire logic [15:0] raw_i,
    output logic [26:0] ticks_o
);
    import rail_seq_pkg::*;
    logic signed [4:0] expo;
    logic [47:0] prod;
    logic [47:0] scaled;
    assign expo = raw_i[15:11];
    always_comb
    begin
        // negative times make no sense, read them as zero
        prod = raw_i[10] ? 48'h0 : 48'(raw_i[9:0]) * 48'(`TICKS_PER_MS);
        if (!expo[4])
            scaled = prod << expo[3:0];
        else
            scaled = prod >> 5'(-expo);
        if (ZERO_PASS && prod == 48'h0)
            ticks_o = 27'h0;
        else if (scaled < 48'(MIN_TICKS))
            ticks_o = MIN_TICKS;
        else if (scaled > 48'(MAX_TICKS))
            ticks_o = MAX_TICKS;
        else
            ticks_o = scaled[26:0];
    end
endmodule : linear_to_ticks
`default_nettype wire

// ---- hdl/interval_timer.sv ----
// down-counter in 10us ticks with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic abort_i,
    input wire logic [26:0] count_i,
    output logic busy_o,
    output logic done_o
);
    import rail_seq_pkg::*;
    ticks_t remain;
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            remain <= 27'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (abort_i)
                busy_o <= 1'b0;
            else if (load_i && count_i == 27'h0)
                done_o <= 1'b1;
            else if (load_i)
            begin
                remain <= count_i;
                busy_o <= 1'b1;
            end
            else if (busy_o && tick_i)
            begin
                remain <= remain - 27'h1;
                if (remain == 27'h1)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule : interval_timer
`default_nettype wire

// ---- hdl/rail_off_restart_retry_seq.sv ----
// one channel of turn-off ramp, restart hold and fault retry sequencing
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
module rail_off_restart_retry_seq #(
    parameter int TICK_CYC = `TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    output logic [15:0] rd_data_o,
    output logic cmd_ack_o,
    output logic cmd_unknown_o,
    input wire logic [15:0] target_level_i,
    input wire logic [15:0] vout_i,
    input wire logic stop_i,
    input wire logic on_i,
    input wire logic run_in_i,
    output logic run_out_o,
    output logic run_oe_n_o,
    input wire logic fault_vin_ov_i,
    input wire logic fault_vout_ov_i,
    input wire logic fault_vout_uv_i,
    input wire logic fault_ton_max_i,
    input wire logic clear_faults_i,
    output logic [15:0] ref_level_o,
    output logic stage_off_o,
    output logic ccm_o,
    output logic start_o,
    output logic off_warn_o,
    output logic status_none_above_o,
    output logic status_input_o,
    output logic status_vin_ov_o,
    output logic alert_o
);
    import rail_seq_pkg::*;

    seq_state_t state;
    seq_state_t next_state;
    logic [7:0] output_overvoltage_action;
    logic [7:0] output_undervoltage_action;
    logic [7:0] input_overvoltage_action;
    logic [7:0] startup_timeout_action;
    logic [7:0] channel_config;
    logic [15:0] turn_off_delay;
    logic [15:0] output_fall_time;
    logic [15:0] off_timeout_warn_limit;
    logic [15:0] fault_retry_interval;
    logic [15:0] run_restart_hold;
    ticks_t delay_ticks;
    ticks_t fall_ticks;
    ticks_t warn_ticks;
    ticks_t retry_ticks;
    ticks_t hold_ticks;
    ticks_t slope_ticks;
    ticks_t fall_eff;
    logic [9:0] tick_cnt;
    logic tick;
    logic [15:0] ramp_from;
    logic [39:0] ramp_acc;
    logic [39:0] acc_sum;
    logic [39:0] fall_cycles;
    logic run_d;
    logic run_fall;
    logic vout_low;
    logic decay_opt;
    logic fault_hit;
    logic [7:0] resp;
    logic retry_ok;
    logic seq_load;
    logic seq_abort;
    logic seq_done;
    logic hold_busy;
    logic hold_done;
    logic hold_elapsed;
    logic retry_done;
    logic retry_elapsed;

    // command port: bytes for actions, two linear bytes for timings
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            output_overvoltage_action <= `RST_OUT_RESP;
            output_undervoltage_action <= `RST_OUT_RESP;
            input_overvoltage_action <= `RST_VIN_OV;
            startup_timeout_action <= `RST_OUT_RESP;
            channel_config <= `RST_CHAN_CFG;
            turn_off_delay <= `RST_OFF_DELAY;
            output_fall_time <= `RST_FALL_TIME;
            off_timeout_warn_limit <= `RST_TOFF_WARN;
            fault_retry_interval <= `RST_RETRY;
            run_restart_hold <= `RST_RESTART;
        end
        else if (cmd_valid_i && cmd_write_i)
        begin
            unique case (cmd_code_i)
                `CMD_VOUT_OV: output_overvoltage_action <= cmd_data_i[7:0];
                `CMD_VOUT_UV: output_undervoltage_action <= cmd_data_i[7:0];
                `CMD_VIN_OV: input_overvoltage_action <= cmd_data_i[7:0];
                `CMD_TON_MAX: startup_timeout_action <= cmd_data_i[7:0];
                `CMD_CHAN_CFG: channel_config <= cmd_data_i[7:0];
                `CMD_OFF_DELAY: turn_off_delay <= cmd_data_i;
                `CMD_FALL_TIME: output_fall_time <= cmd_data_i;
                `CMD_TOFF_WARN: off_timeout_warn_limit <= cmd_data_i;
                `CMD_RETRY: fault_retry_interval <= cmd_data_i;
                `CMD_RESTART: run_restart_hold <= cmd_data_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rd_data_o <= 16'h0000;
            cmd_ack_o <= 1'b0;
            cmd_unknown_o <= 1'b0;
        end
        else
        begin
            cmd_ack_o <= cmd_valid_i;
            cmd_unknown_o <= 1'b0;
            if (cmd_valid_i)
            begin
                unique case (cmd_code_i)
                    `CMD_VOUT_OV: rd_data_o <= {8'h00, output_overvoltage_action};
                    `CMD_VOUT_UV: rd_data_o <= {8'h00, output_undervoltage_action};
                    `CMD_VIN_OV: rd_data_o <= {8'h00, input_overvoltage_action};
                    `CMD_TON_MAX: rd_data_o <= {8'h00, startup_timeout_action};
                    `CMD_CHAN_CFG: rd_data_o <= {8'h00, channel_config};
                    `CMD_OFF_DELAY: rd_data_o <= turn_off_delay;
                    `CMD_FALL_TIME: rd_data_o <= output_fall_time;
                    `CMD_TOFF_WARN: rd_data_o <= off_timeout_warn_limit;
                    `CMD_RETRY: rd_data_o <= fault_retry_interval;
                    `CMD_RESTART: rd_data_o <= run_restart_hold;
                    default:
                    begin
                        rd_data_o <= 16'h0000;
                        cmd_unknown_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    linear_to_ticks #(.MIN_TICKS(27'h0),
        .MAX_TICKS(27'(`MS_TICKS(`DELAY_MAX_MS))))
        u_dec_delay (.raw_i(turn_off_delay), .ticks_o(delay_ticks));
    linear_to_ticks #(.MIN_TICKS(27'(`FALL_MIN_TICKS)),
        .MAX_TICKS(27'(`MS_TICKS(`FALL_MAX_MS))))
        u_dec_fall (.raw_i(output_fall_time), .ticks_o(fall_ticks));
    linear_to_ticks #(.MIN_TICKS(27'(`MS_TICKS(`WARN_MIN_MS))),
        .MAX_TICKS(27'(`MS_TICKS(`WARN_MAX_MS))), .ZERO_PASS(1'b1))
        u_dec_warn (.raw_i(off_timeout_warn_limit), .ticks_o(warn_ticks));
    linear_to_ticks #(.MIN_TICKS(27'(`MS_TICKS(`RETRY_MIN_MS))),
        .MAX_TICKS(27'(`MS_TICKS(`RETRY_MAX_MS))))
        u_dec_retry (.raw_i(fault_retry_interval), .ticks_o(retry_ticks));
    linear_to_ticks #(.MIN_TICKS(27'(`MS_TICKS(`HOLD_MIN_MS))),
        .MAX_TICKS(27'(`MS_TICKS(`HOLD_MAX_MS))))
        u_dec_hold (.raw_i(run_restart_hold), .ticks_o(hold_ticks));

    // 10us timebase shared by all timers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || tick)
            tick_cnt <= 10'h000;
        else
            tick_cnt <= tick_cnt + 10'h001;
    end
    assign tick = tick_cnt == 10'(TICK_CYC - 1);

    assign decay_opt = channel_config[`CFG_DECAY_WAIT];
    assign vout_low = vout_i < (target_level_i >> `OFF_LEVEL_SHIFT);
    assign run_fall = run_d && !run_in_i && run_oe_n_o;
    assign fault_hit = fault_vin_ov_i || fault_vout_ov_i ||
        fault_vout_uv_i || fault_ton_max_i;

    always_comb
    begin
        if (fault_vin_ov_i)
            resp = input_overvoltage_action;
        else if (fault_vout_ov_i)
            resp = output_overvoltage_action;
        else if (fault_vout_uv_i)
            resp = output_undervoltage_action;
        else
            resp = startup_timeout_action;
    end
    assign retry_ok = resp != `RESP_LATCH_OFF &&
        resp[5:3] == `RESP_RETRY_ALL;

    always_comb
    begin
        next_state = state;
        if (fault_hit && state != ST_LATCH)
            next_state = retry_ok ? ST_RETRY : ST_LATCH;
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (stop_i || run_fall)
                        next_state = ST_DELAY;
                ST_DELAY:
                    if (seq_done)
                        next_state = ST_FALL;
                ST_FALL:
                    if (ref_level_o == 16'h0000)
                        next_state = ST_TRI;
                ST_TRI:
                    next_state = decay_opt ? ST_DECAY : ST_OFF;
                ST_DECAY:
                    if (vout_low)
                        next_state = ST_OFF;
                ST_OFF:
                    if (!hold_busy && (hold_elapsed || on_i) &&
                        (!decay_opt || vout_low))
                        next_state = ST_IDLE;
                ST_RETRY:
                    if (retry_elapsed && (vout_low ||
                        channel_config[`CFG_NO_RETRY_DECAY]))
                        next_state = ST_IDLE;
                ST_LATCH:
                    if (clear_faults_i)
                        next_state = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // delay and warn share one timer; they never overlap in time
    assign seq_load = (next_state == ST_DELAY && state != ST_DELAY) ||
        (next_state == ST_DECAY && state != ST_DECAY &&
        warn_ticks != 27'h0);
    assign seq_abort = next_state != ST_DELAY && next_state != ST_DECAY;
    interval_timer u_seq_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .load_i(seq_load),
        .abort_i(seq_abort),
        .count_i(state == ST_TRI ? warn_ticks : delay_ticks),
        .busy_o(),
        .done_o(seq_done)
    );
    interval_timer u_hold_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .load_i(run_fall),
        .abort_i(1'b0),
        .count_i(hold_ticks),
        .busy_o(hold_busy),
        .done_o(hold_done)
    );
    interval_timer u_retry_tmr (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .load_i(fault_hit && retry_ok && state != ST_LATCH),
        .abort_i(1'b0),
        .count_i(retry_ticks),
        .busy_o(),
        .done_o(retry_done)
    );

    // run pin: open drain, only ever pulled low
    assign run_out_o = 1'b0;
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            run_d <= 1'b1;
            run_oe_n_o <= 1'b1;
        end
        else
        begin
            run_d <= run_in_i;
            run_oe_n_o <= !(run_fall || (hold_busy && !hold_done));
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            hold_elapsed <= 1'b0;
            retry_elapsed <= 1'b0;
        end
        else
        begin
            if (hold_done)
                hold_elapsed <= 1'b1;
            else if (run_fall || next_state == ST_IDLE)
                hold_elapsed <= 1'b0;
            if (retry_done)
                retry_elapsed <= 1'b1;
            else if (fault_hit || next_state == ST_IDLE)
                retry_elapsed <= 1'b0;
        end
    end

    // ramp: add the start level each clock, step once per fall_cycles
    // so the start level is consumed in exactly fall_eff ticks
    // at most one step a clock: exact only while fall_cycles >= ramp_from
    assign slope_ticks = 27'((32'(ramp_from) + `SLOPE_MV_PER_TICK - 1) /
        `SLOPE_MV_PER_TICK);
    assign fall_eff = fall_ticks > slope_ticks ? fall_ticks : slope_ticks;
    assign fall_cycles = 40'(fall_eff) * 40'(TICK_CYC);
    assign acc_sum = ramp_acc + 40'(ramp_from);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ref_level_o <= 16'h0000;
            ramp_from <= 16'h0000;
            ramp_acc <= 40'h0;
        end
        else if (state == ST_IDLE || state == ST_DELAY)
        begin
            ref_level_o <= target_level_i;
            ramp_from <= target_level_i;
            ramp_acc <= 40'h0;
        end
        else if (state == ST_FALL)
        begin
            if (acc_sum >= fall_cycles)
            begin
                ramp_acc <= acc_sum - fall_cycles;
                if (ref_level_o != 16'h0000)
                    ref_level_o <= ref_level_o - 16'h0001;
            end
            else
                ramp_acc <= acc_sum;
        end
        else
            ref_level_o <= 16'h0000;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            stage_off_o <= 1'b0;
            ccm_o <= 1'b0;
            start_o <= 1'b0;
        end
        else
        begin
            stage_off_o <= !(next_state inside {ST_IDLE, ST_DELAY, ST_FALL});
            ccm_o <= channel_config[`CFG_CCM];
            start_o <= next_state == ST_IDLE &&
                (state == ST_OFF || state == ST_RETRY);
        end
    end

    // status flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            off_warn_o <= 1'b0;
            status_none_above_o <= 1'b0;
            status_input_o <= 1'b0;
            status_vin_ov_o <= 1'b0;
            alert_o <= 1'b0;
        end
        else
        begin
            if (state == ST_DECAY && seq_done && !vout_low)
                off_warn_o <= 1'b1;
            else if (clear_faults_i)
                off_warn_o <= 1'b0;
            if (fault_vin_ov_i)
            begin
                status_none_above_o <= 1'b1;
                status_input_o <= 1'b1;
                status_vin_ov_o <= 1'b1;
                alert_o <= 1'b1;
            end
            else if (clear_faults_i)
            begin
                status_none_above_o <= 1'b0;
                status_input_o <= 1'b0;
                status_vin_ov_o <= 1'b0;
                alert_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_fall_done;
        state == ST_FALL && ref_level_o == 16'h0000 && !fault_hit;
    endsequence
    sequence s_off_tri;
        stage_off_o && state == ST_TRI;
    endsequence

    AST_ZERO_THEN_TRI: assert property (s_fall_done |=> s_off_tri)
        else $error("zero reference did not three-state");
    AST_DELAY_TO_FALL: assert property (
        state == ST_DELAY && seq_done && !fault_hit |=> state == ST_FALL)
        else $error("delay expiry did not start ramp");
    AST_FALL_MIN: assert property (fall_eff >= 27'(`FALL_MIN_TICKS))
        else $error("fall time below minimum");
    AST_FALL_MAX: assert property (
        fall_eff <= 27'(`MS_TICKS(`FALL_MAX_MS)) && fall_eff >= slope_ticks)
        else $error("fall time out of range");
    AST_RUN_HOLD: assert property (run_fall |=> !run_oe_n_o [*2])
        else $error("run pin not held low");
    AST_HOLD_START: assert property (
        state == ST_OFF && hold_elapsed && !hold_busy && !decay_opt &&
        !fault_hit |=> start_o && state == ST_IDLE)
        else $error("hold expiry did not restart");
    AST_DECAY_BLOCK: assert property (
        state == ST_OFF && decay_opt && !vout_low |=> !start_o)
        else $error("restart before output decayed");
    AST_VIN_STATUS: assert property (fault_vin_ov_i |=>
        status_none_above_o && status_input_o && status_vin_ov_o && alert_o)
        else $error("input overvoltage status missing");
    AST_LATCH_OFF: assert property (
        fault_hit && resp == `RESP_LATCH_OFF |=> state == ST_LATCH ##1
        stage_off_o)
        else $error("latch-off action not taken");
    AST_WARN_CAUSE: assert property (
        $rose(off_warn_o) |-> $past(state) == ST_DECAY && decay_opt)
        else $error("warning outside decay wait");
    AST_RETRY_TIMED: assert property (
        fault_hit && retry_ok && state != ST_LATCH |=>
        state == ST_RETRY && !retry_elapsed)
        else $error("retry not timed from detection");
endmodule : rail_off_restart_retry_seq
`default_nettype wire

// ---- testbench/host_model.sv ----
// register host that drives the command port of the sequencer
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_sys_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] cmd_data_o,
    input wire logic [15:0] rd_data_i,
    input wire logic cmd_ack_i,
    input wire logic cmd_unknown_i
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_data_o = 16'h0000;
    end
    // one strobe carries the whole linear word, answer one cycle later
    task xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
        output logic [15:0] rd, output logic unk);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= wr;
        cmd_code_o <= code;
        cmd_data_o <= data;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
        #1;
        rd = rd_data_i;
        unk = cmd_unknown_i & cmd_ack_i;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// bench for registers, off ramp, faults and run hold of the sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, cmd_valid_i, cmd_write_i, cmd_ack_o;
    logic [7:0] cmd_code_i;
    logic [15:0] cmd_data_i, rd_data_o, ref_level_o, vout_i, r;
    logic [15:0] target_level_i = 16'h0028;
    logic cmd_unknown_o, stop_i = 1'b0, on_i = 1'b0, run_in_i, k;
    logic run_out_o, run_oe_n_o, fault_vin_ov_i = 1'b0, fault_vout_ov_i = 1'b0;
    logic fault_vout_uv_i = 1'b0, fault_ton_max_i = 1'b0, clear_faults_i = 1'b0;
    logic stage_off_o, ccm_o, start_o, off_warn_o, status_none_above_o;
    logic status_input_o, status_vin_ov_o, alert_o, run_drv = 1'b1;
    logic [15:0] mdl [bit [7:0]];
    bit [7:0] cd [4] = '{8'h41, 8'h45, 8'h56, 8'h63};
    int num_errors = 0, compares = 0, cyc = 0, n;
    always #5 clk_sys_i = ~clk_sys_i;
    // run line is open drain with a pull-up
    assign run_in_i = run_drv & run_oe_n_o;
    rail_off_restart_retry_seq #(.TICK_CYC(2)) rail_off_restart_retry_seq_i (
        .clk_sys_i, .rst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
        .cmd_data_i, .rd_data_o, .cmd_ack_o, .cmd_unknown_o, .target_level_i,
        .vout_i, .stop_i, .on_i, .run_in_i, .run_out_o, .run_oe_n_o,
        .fault_vin_ov_i, .fault_vout_ov_i, .fault_vout_uv_i, .fault_ton_max_i,
        .clear_faults_i, .ref_level_o, .stage_off_o, .ccm_o, .start_o,
        .off_warn_o, .status_none_above_o, .status_input_o, .status_vin_ov_o,
        .alert_o);
    host_model host_model_i (.clk_sys_i, .cmd_valid_o(cmd_valid_i),
        .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i),
        .cmd_data_o(cmd_data_i), .rd_data_i(rd_data_o), .cmd_ack_i(cmd_ack_o),
        .cmd_unknown_i(cmd_unknown_o));
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input bit [7:0] c);
        host_model_i.xfer(1'b0, c, 16'h0000, r, k);
        chk(r, mdl.exists(c) ? mdl[c] : 16'h0000);
        chk({15'h0, cmd_ack_o}, 16'h0001);
        chk({15'h0, k}, {15'h0, !mdl.exists(c)});
    endtask : rd
    task wr(input bit [7:0] c, input logic [15:0] d);
        host_model_i.xfer(1'b1, c, d, r, k);
        mdl[c] = (c inside {cd, 8'hD0}) ? {8'h00, d[7:0]} : d;
    endtask : wr
    function automatic logic hit(input int s);
        case (s)
            0: return stage_off_o;
            1: return start_o;
            2: return !run_oe_n_o;
            default: return run_oe_n_o;
        endcase
    endfunction : hit
    task wt(input int s, input int lim);
        n = 0;
        while (hit(s) !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
    endtask : wt
    task tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        vout_i = 16'h0000;
        mdl = '{8'h41: 16'h00B8, 8'h45: 16'h00B8, 8'h56: 16'h0080,
            8'h63: 16'h00B8, 8'h64: 16'h8000, 8'h65: 16'hD200,
            8'h66: 16'hF258, 8'hD0: 16'h0000, 8'hDB: 16'hFABC,
            8'hDC: 16'hFBE8};
        void'($urandom(32'h5a79181b));
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // output stays under an eighth of target, so it counts as off
        vout_i <= 16'($urandom_range(4));
        foreach (mdl[c]) rd(c);
        rd(8'h01);
        foreach (cd[i])
        begin
            wr(cd[i], 16'($urandom));
            rd(cd[i]);
        end
        wr(8'h56, 16'h0080);
        wr(8'h45, 16'h00B8);
        $display("test registers done");
        wr(8'h64, 16'h0000);
        wr(8'h65, 16'h0000);
        wr(8'hD0, 16'h0004);
        @(posedge clk_sys_i);
        stop_i <= 1'b1;
        @(posedge clk_sys_i);
        stop_i <= 1'b0;
        wt(0, 400);
        chk(16'(n >= 50 && n <= 62), 16'h0001);
        chk(ref_level_o, 16'h0000);
        chk({15'h0, ccm_o}, 16'h0001);
        chk({15'h0, off_warn_o}, 16'h0000);
        $display("test off ramp done");
        @(posedge clk_sys_i);
        fault_vin_ov_i <= 1'b1;
        @(posedge clk_sys_i);
        fault_vin_ov_i <= 1'b0;
        wt(1, 300);
        chk({12'h0, status_none_above_o, status_input_o, status_vin_ov_o,
            alert_o}, 16'h000F);
        chk(16'(n), 16'd300);
        @(posedge clk_sys_i);
        clear_faults_i <= 1'b1;
        @(posedge clk_sys_i);
        clear_faults_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk({15'h0, alert_o}, 16'h0000);
        $display("test latch done");
        wr(8'hDB, 16'h0078);
        @(posedge clk_sys_i);
        fault_vout_uv_i <= 1'b1;
        @(posedge clk_sys_i);
        fault_vout_uv_i <= 1'b0;
        wt(1, 26000);
        chk(16'(n >= 23996 && n <= 24008), 16'h0001);
        $display("test retry done");
        wr(8'hDC, 16'h0088);
        @(posedge clk_sys_i);
        run_drv <= 1'b0;
        wt(2, 8);
        chk({15'h0, run_oe_n_o}, 16'h0000);
        chk({15'h0, run_out_o}, 16'h0000);
        @(posedge clk_sys_i);
        run_drv <= 1'b1;
        wt(3, 30000);
        chk(16'(n >= 27190 && n <= 27204), 16'h0001);
        wt(1, 50);
        chk(16'(n < 50), 16'h0001);
        $display("test run hold done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
